//--- dbip_alarm.v
// Alarm pin driver: polarity, source select and serial output muxing.
// Assumes all inputs are on pclk.
`timescale 1ns/1ps
`include "dbip_defs.vh"
module dbip_alarm (
	// Clock and reset.
	input  wire       pclk,
	input  wire       presetn,
	// Configuration.
	input  wire       alarm_pol,
	input  wire       four_wire_serial_sel,
	input  wire [7:0] alarm_source_config,
	// Conditions and serial data.
	input  wire [3:0] cond,
	input  wire       serial_rd_data,
	// Pin.
	output reg        alarm_or_serial_out_pin
);
	wire any_alarm;

	assign any_alarm = |(cond & alarm_source_config[3:0]);

	// Registered pin avoids glitches when polarity or source changes.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_or_serial_out_pin <= 1'b1;
		end else if (four_wire_serial_sel) begin
			alarm_or_serial_out_pin <= serial_rd_data;
		end else begin
			alarm_or_serial_out_pin <= alarm_pol ? any_alarm : ~any_alarm;
		end
	end
endmodule // dbip_alarm

//--- dbip_chk_assertions.sv
// Checker for the byte port block, bound to its top module.
// Assumes APB writes land where psel, penable, pwrite and pready are high.
`timescale 1ns/1ps
`include "dbip_defs.vh"
module dbip_chk #(
	parameter STALL_CYC = 50
) (
	// Clock, reset and APB.
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire        pready,
	input wire        pslverr,
	// Link, serial and outputs.
	input wire        transmit_gate,
	input wire        serial_rd_data,
	input wire        serial_drive_req,
	input wire        serial_data_out,
	input wire        serial_data_oe,
	input wire [15:0] sample_a,
	input wire [15:0] sample_b,
	input wire        sample_valid,
	input wire        fifo_reset,
	input wire        alarm_or_serial_out_pin
);
	// ----------------------------------------
	// Shadow of the alarm configuration.
	// ----------------------------------------
	reg  [3:0] src_r;
	reg        pol_r;
	reg        sif_r;
	wire       wr = psel && penable && pwrite && pready;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_r <= 4'h0;
			pol_r <= 1'b0;
			sif_r <= 1'b0;
		end else if (wr && paddr == `DBIP_OFF_GENCFG) begin
			pol_r <= pwdata[`DBIP_GEN_ALMPOL];
			sif_r <= pwdata[`DBIP_GEN_SIF4];
		end else if (wr && paddr == `DBIP_OFF_ALMSRC) begin
			src_r <= pwdata[3:0];
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_RST_IDLE: assert property ($rose(presetn) |-> alarm_or_serial_out_pin)
		else $error("alarm pin not idle after reset");
	AST_POL_IDLE: assert property (src_r == 4'h0 && !sif_r |=>
		alarm_or_serial_out_pin == !$past(pol_r))
		else $error("alarm idle level wrong");
	AST_SIF_DATA: assert property (sif_r |=>
		alarm_or_serial_out_pin == $past(serial_rd_data))
		else $error("serial read data not on alarm pin");
	AST_SDO_PATH: assert property (serial_data_oe == serial_drive_req &&
		serial_data_out == serial_rd_data)
		else $error("serial data pin path wrong");
	AST_GATE_ZERO: assert property (!transmit_gate [*6] |->
		sample_a == 16'h0000 && sample_b == 16'h0000)
		else $error("samples not zero with gate low");
	AST_FRAME_PULSE: assert property (fifo_reset |=> !fifo_reset [*4])
		else $error("buffer reset pulse too long");
	AST_VALID_GAP: assert property (sample_valid |=> !sample_valid [*8])
		else $error("sample pair faster than four bytes");
	AST_UNMAPPED: assert property (psel && penable && paddr > `DBIP_OFF_SAMPLE |-> pslverr)
		else $error("unmapped access not refused");
	COV_PAIR: cover property (sample_valid);
	COV_SIF: cover property (sif_r && serial_rd_data);
	COV_ERR: cover property (psel && penable && pslverr);
endmodule // dbip_chk

bind dbip_top dbip_chk #(.STALL_CYC(STALL_CYC)) chk_u (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
	.transmit_gate(transmit_gate), .serial_rd_data(serial_rd_data),
	.serial_drive_req(serial_drive_req), .serial_data_out(serial_data_out),
	.serial_data_oe(serial_data_oe), .sample_a(sample_a), .sample_b(sample_b),
	.sample_valid(sample_valid), .fifo_reset(fifo_reset),
	.alarm_or_serial_out_pin(alarm_or_serial_out_pin)
);

//--- dbip_defs.vh
// Constants for the byte-wide input port and alarm pin block.
// Assumes inclusion by bare name; definitions only.
//
// Functional notes
// - Bytes are taken on both data clock edges, two per period.
// - Two 16-bit channel samples travel as four bytes, framed by the strobe.
// - Default lane 7 is the MSB and lane 0 the LSB.
// - The reverse control makes the device read lanes in reversed order.
// - Alarm is active low after reset; polarity bit makes it active high.
// - The alarm source register selects which conditions drive the alarm.
// - With four-wire select set, the alarm pin carries serial read data.
// - Frame strobe taken on rising clock edge; starts frame, resets buffer.
// - Serial data pin stays bidirectional in three- and four-wire modes.
// - With transmit gate low, datapath is forced to zero, bytes ignored; the strobe still pulses fifo_reset.
`ifndef DBIP_DEFS_VH
`define DBIP_DEFS_VH

// -----------------------------------------------------------------------------
// Register offsets.
// -----------------------------------------------------------------------------
`define DBIP_OFF_GENCFG   12'h000
`define DBIP_OFF_ALMSRC   12'h004
`define DBIP_OFF_BUSCFG   12'h008
`define DBIP_OFF_STATUS   12'h00C
`define DBIP_OFF_MASK     12'h010
`define DBIP_OFF_SAMPLE   12'h014

// -----------------------------------------------------------------------------
// Field positions.
// -----------------------------------------------------------------------------
`define DBIP_GEN_ALMPOL   0
`define DBIP_GEN_SIF4     1
`define DBIP_BUS_REV      0
`define DBIP_ST_FRAME     0
`define DBIP_ST_ALIGN     1
`define DBIP_ST_GATE      2
`define DBIP_ST_CLKSTOP   3
`define DBIP_EVT_W        4

// -----------------------------------------------------------------------------
// Reset values.
// -----------------------------------------------------------------------------
`define DBIP_RST_GENCFG   8'h00
`define DBIP_RST_ALMSRC   8'h00
`define DBIP_RST_BUSCFG   8'h00
`define DBIP_RST_MASK     4'h0

// -----------------------------------------------------------------------------
// Timing: clock stall watchdog in ns and its count at 40 ns per cycle.
// -----------------------------------------------------------------------------
`define DBIP_PCLK_NS      40
`define DBIP_STALL_NS     2000
`define DBIP_STALL_CYC    (`DBIP_STALL_NS / `DBIP_PCLK_NS)

`endif

//--- dbip_src.sv
// Link source model: byte bus, frame strobe and link clock.
// Assumes the bench calls send; the clock rests low between frames.
`timescale 1ns/1ps
module dbip_src (
	// Link pins.
	output reg       lclk,
	output reg       frame,
	output reg [7:0] dbyte
);
	initial begin
		lclk = 1'b0;
		frame = 1'b0;
		dbyte = 8'h00;
	end
	task send(input [31:0] w);
		integer i;
		begin
			// Stay clear of pclk edges so the pins never race the sampling flops.
			#10;
			for (i = 0; i < 4; i = i + 1) begin
				dbyte = w[31-8*i -: 8];
				frame = (i == 0);
				#80;
				lclk = ~lclk;
				#80;
			end
			frame = 1'b0;
			// A released bus must not show the last byte again.
			dbyte = ~dbyte;
		end
	endtask
endmodule // dbip_src

//--- dbip_sync.v
// Two-flop synchroniser for a bundle of asynchronous levels.
// Assumes inputs come from pins outside the pclk domain.
`timescale 1ns/1ps
module dbip_sync #(
	parameter W = 1
) (
	// Clock and reset.
	input  wire         pclk,
	input  wire         presetn,
	// Levels.
	input  wire [W-1:0] d,
	output wire [W-1:0] q
);
	reg [W-1:0] s1_r;
	reg [W-1:0] s2_r;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r <= {W{1'b0}};
			s2_r <= {W{1'b0}};
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
		end
	end
	assign q = s2_r;
endmodule // dbip_sync

//--- dbip_top.v
// Byte-wide DDR input port with alarm pin and APB register slave.
// Assumes the link clock, bytes, frame and gate are asynchronous pins
// oversampled by pclk; the link clock must be well below pclk/4.
`timescale 1ns/1ps
`include "dbip_defs.vh"
module dbip_top #(
	parameter STALL_CYC = `DBIP_STALL_CYC
) (
	// Clock and reset.
	input  wire        pclk,
	input  wire        presetn,
	// APB slave.
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	// Link pins.
	input  wire        source_data_clock_pair,
	input  wire        frame_strobe_pair,
	input  wire [7:0]  data_byte,
	input  wire        transmit_gate,
	// Serial data pin, split.
	input  wire        serial_data_in,
	input  wire        serial_rd_data,
	output wire        serial_data_out,
	output wire        serial_data_oe,
	input  wire        serial_drive_req,
	// Sample outputs.
	output reg  [15:0] sample_a,
	output reg  [15:0] sample_b,
	output reg         sample_valid,
	output wire        fifo_reset,
	// Alarm and interrupt.
	output wire        alarm_or_serial_out_pin,
	output wire        irq
);
	// -------------------------------------------------------------------------
	// Functions.
	// -------------------------------------------------------------------------
	function [7:0] bit_rev;
		input [7:0] v;
		integer i;
		begin
			for (i = 0; i < 8; i = i + 1) begin
				bit_rev[i] = v[7-i];
			end
		end
	endfunction

	// -------------------------------------------------------------------------
	// Pin synchronisation.
	// -------------------------------------------------------------------------
	wire [11:0] sync_q;
	wire        dclk_s;
	wire        frame_s;
	wire        gate_s;
	wire [7:0]  byte_s;

	dbip_sync #(.W(12)) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       ({serial_data_in, transmit_gate, frame_strobe_pair,
		           source_data_clock_pair, data_byte}),
		.q       (sync_q)
	);
	assign byte_s  = sync_q[7:0];
	assign dclk_s  = sync_q[8];
	assign frame_s = sync_q[9];
	assign gate_s  = sync_q[10];

	// -------------------------------------------------------------------------
	// Registers.
	// -------------------------------------------------------------------------
	reg  [7:0]  gencfg_r;
	reg  [7:0]  almsrc_r;
	reg  [7:0]  buscfg_r;
	reg  [3:0]  status_r;
	reg  [3:0]  mask_r;
	reg  [3:0]  status_nxt;
	reg  [3:0]  evt;
	wire        wr_en;
	wire        rd_en;
	wire        addr_ok;

	assign pready  = 1'b1;
	assign wr_en   = psel & penable & pwrite;
	assign rd_en   = psel & penable & ~pwrite;
	assign addr_ok = (paddr == `DBIP_OFF_GENCFG) | (paddr == `DBIP_OFF_ALMSRC) |
	                 (paddr == `DBIP_OFF_BUSCFG) | (paddr == `DBIP_OFF_STATUS) |
	                 (paddr == `DBIP_OFF_MASK)   | (paddr == `DBIP_OFF_SAMPLE);
	assign pslverr = psel & penable & ~addr_ok;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gencfg_r <= `DBIP_RST_GENCFG;
			almsrc_r <= `DBIP_RST_ALMSRC;
			buscfg_r <= `DBIP_RST_BUSCFG;
			mask_r   <= `DBIP_RST_MASK;
		end else if (wr_en) begin
			case (paddr)
				`DBIP_OFF_GENCFG: begin
					gencfg_r <= pwdata[7:0];
				end
				`DBIP_OFF_ALMSRC: begin
					almsrc_r <= pwdata[7:0];
				end
				`DBIP_OFF_BUSCFG: begin
					buscfg_r <= pwdata[7:0];
				end
				`DBIP_OFF_MASK: begin
					mask_r <= pwdata[3:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Set wins over a write-one clear in the same cycle.
	always @* begin
		status_nxt = status_r;
		if (wr_en && paddr == `DBIP_OFF_STATUS) begin
			status_nxt = status_nxt & ~pwdata[3:0];
		end
		status_nxt = status_nxt | evt;
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_r <= 4'h0;
		end else begin
			status_r <= status_nxt;
		end
	end

	assign irq = |(status_r & mask_r);

	always @* begin
		case (paddr)
			`DBIP_OFF_GENCFG: prdata = {24'h00_0000, gencfg_r};
			`DBIP_OFF_ALMSRC: prdata = {24'h00_0000, almsrc_r};
			`DBIP_OFF_BUSCFG: prdata = {24'h00_0000, buscfg_r};
			`DBIP_OFF_STATUS: prdata = {28'h000_0000, status_r};
			`DBIP_OFF_MASK:   prdata = {28'h000_0000, mask_r};
			`DBIP_OFF_SAMPLE: prdata = {sample_a, sample_b};
			default:          prdata = 32'h0000_0000;
		endcase
		if (!rd_en) begin
			prdata = 32'h0000_0000;
		end
	end

	// -------------------------------------------------------------------------
	// Link edge detection and byte capture.
	// -------------------------------------------------------------------------
	reg         dclk_d_r;
	reg  [1:0]  idx_r;
	reg  [7:0]  b0_r;
	reg  [7:0]  b1_r;
	reg  [7:0]  b2_r;
	reg         framed_r;
	reg  [15:0] stall_r;
	reg         gate_d_r;
	wire        rise;
	wire        fall;
	wire        edge_any;
	wire        frame_start;
	wire [7:0]  byte_ord;

	assign rise     = dclk_s & ~dclk_d_r;
	assign fall     = ~dclk_s & dclk_d_r;
	assign edge_any = rise | fall;
	assign frame_start = rise & frame_s;
	assign fifo_reset  = frame_start;
	assign byte_ord = buscfg_r[`DBIP_BUS_REV] ? bit_rev(byte_s) : byte_s;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dclk_d_r     <= 1'b0;
			gate_d_r     <= 1'b0;
			idx_r        <= 2'd0;
			b0_r         <= 8'h00;
			b1_r         <= 8'h00;
			b2_r         <= 8'h00;
			framed_r     <= 1'b0;
			sample_a     <= 16'h0000;
			sample_b     <= 16'h0000;
			sample_valid <= 1'b0;
			stall_r      <= 16'h0000;
		end else begin
			dclk_d_r     <= dclk_s;
			gate_d_r     <= gate_s;
			sample_valid <= 1'b0;
			if (edge_any || stall_r == STALL_CYC[15:0]) begin
				stall_r <= edge_any ? 16'h0000 : stall_r;
			end else begin
				stall_r <= stall_r + 16'h0001;
			end
			if (!gate_s) begin
				idx_r    <= 2'd0;
				framed_r <= 1'b0;
				sample_a <= 16'h0000;
				sample_b <= 16'h0000;
			end else if (edge_any) begin
				// four bytes per sample pair, MSB byte first.
				if (frame_start) begin
					b0_r     <= byte_ord;
					idx_r    <= 2'd1;
					framed_r <= 1'b1;
				end else if (framed_r) begin
					case (idx_r)
						2'd0: begin
							b0_r <= byte_ord;
						end
						2'd1: begin
							b1_r <= byte_ord;
						end
						2'd2: begin
							b2_r <= byte_ord;
						end
						default: begin
							sample_a     <= {b0_r, b1_r};
							sample_b     <= {b2_r, byte_ord};
							sample_valid <= 1'b1;
						end
					endcase
					idx_r <= idx_r + 2'd1;
				end
			end
		end
	end

	// Events: frame seen, misaligned frame, gate fall, clock stall.
	always @* begin
		evt = 4'h0;
		evt[`DBIP_ST_FRAME]   = frame_start & gate_s;
		evt[`DBIP_ST_ALIGN]   = frame_start & gate_s & framed_r & (idx_r != 2'd0);
		evt[`DBIP_ST_GATE]    = gate_d_r & ~gate_s;
		evt[`DBIP_ST_CLKSTOP] = (stall_r == STALL_CYC[15:0] - 16'h0001) & ~edge_any;
	end

	// -------------------------------------------------------------------------
	// Serial data pin and alarm.
	// -------------------------------------------------------------------------
	// bidirectional in both serial modes.
	assign serial_data_oe  = serial_drive_req;
	assign serial_data_out = serial_rd_data;

	dbip_alarm u_alarm (
		.pclk                    (pclk),
		.presetn                 (presetn),
		.alarm_pol               (gencfg_r[`DBIP_GEN_ALMPOL]),
		.four_wire_serial_sel    (gencfg_r[`DBIP_GEN_SIF4]),
		.alarm_source_config     (almsrc_r),
		.cond                    (status_r),
		.serial_rd_data          (serial_rd_data),
		.alarm_or_serial_out_pin (alarm_or_serial_out_pin)
	);
endmodule // dbip_top

//--- ddr_byte_input_port_alarm_pin_tb.sv
// Self-checking bench for the byte port block.
// Assumes the stall count is shortened to 8 cycles.
`timescale 1ns/1ps
`include "dbip_defs.vh"
module ddr_byte_input_port_alarm_pin_tb;
	reg         pclk = 1'b0;
	reg         presetn = 1'b0;
	reg         psel = 1'b0;
	reg         penable = 1'b0;
	reg         pwrite = 1'b0;
	reg  [11:0] paddr = 12'h000;
	reg  [31:0] pwdata = 32'h0000_0000;
	reg         transmit_gate = 1'b1;
	reg         serial_rd_data = 1'b0;
	reg         serial_drive_req = 1'b0;
	wire [31:0] prdata;
	wire        pready, pslverr, lclk, frame, sdo, soe, sample_valid, fifo_reset, pin, irq;
	wire [7:0]  dbyte;
	wire [15:0] sample_a, sample_b;
	// The serial data line has a pull-down when nobody drives it.
	wire        sdio = soe ? sdo : 1'b0;
	integer     n_errors = 0;
	integer     num_checks = 0;
	integer     n_fr = 0;
	reg  [31:0] q[$];
	reg  [31:0] rd, last;
	reg         er;
	reg         rev;
	integer     k;
	dbip_top #(.STALL_CYC(8)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .source_data_clock_pair(lclk),
		.frame_strobe_pair(frame), .data_byte(dbyte), .transmit_gate(transmit_gate),
		.serial_data_in(sdio), .serial_rd_data(serial_rd_data), .serial_data_out(sdo),
		.serial_data_oe(soe), .serial_drive_req(serial_drive_req), .sample_a(sample_a),
		.sample_b(sample_b), .sample_valid(sample_valid), .fifo_reset(fifo_reset),
		.alarm_or_serial_out_pin(pin), .irq(irq));
	dbip_src src_u (.lclk(lclk), .frame(frame), .dbyte(dbyte));
	always #20 pclk = ~pclk;
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			num_checks = num_checks + 1;
			if (seen !== exp) begin
				n_errors = n_errors + 1;
				$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	task stop_test;
		begin
			$display("checks=%0d errors=%0d", num_checks, n_errors);
			if (n_errors == 0 && num_checks > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	task apb(input w, input [11:0] a, input [31:0] d);
		begin
			@(posedge pclk);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			@(posedge pclk);
			while (pready !== 1'b1)
				@(posedge pclk);
			rd = prdata;
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			repeat (2) @(posedge pclk);
		end
	endtask
	function [7:0] rv(input [7:0] x);
		integer i;
		begin
			for (i = 0; i < 8; i = i + 1)
				rv[i] = x[7-i];
		end
	endfunction
	task pair(input on);
		reg [31:0] w;
		integer i;
		integer f;
		begin
			f = n_fr;
			w = $urandom;
			for (i = 0; i < 4; i = i + 1)
				last[8*i +: 8] = rev ? rv(w[8*i +: 8]) : w[8*i +: 8];
			if (on)
				q.push_back(last);
			src_u.send(w);
			repeat (6) @(posedge pclk);
			if (on)
				chk(n_fr - f, 1);
		end
	endtask
	always @(posedge pclk)
		if (fifo_reset === 1'b1)
			n_fr = n_fr + 1;
	always @(posedge pclk)
		if (sample_valid === 1'b1)
			chk({sample_a, sample_b}, q.size() ? q.pop_front() : 32'h0000_0000);
	initial begin
		#2_000_000;
		n_errors = n_errors + 1;
		stop_test;
	end
	initial begin
		void'($urandom(32'h7f76));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		chk(pin, 1);
		for (k = 0; k < 5; k = k + 1) begin
			apb(0, 4 * k, 0);
			chk(rd, (k == 3) ? (32'h1 << `DBIP_ST_CLKSTOP) : 32'h0);
		end
		apb(0, 12'h020, 0);
		chk(er, 1);
		chk(rd, 0);
		for (k = 0; k < 2; k = k + 1) begin
			rev = k;
			apb(1, `DBIP_OFF_BUSCFG, k);
			repeat (2) pair(1);
			chk(q.size(), 0);
		end
		apb(0, `DBIP_OFF_SAMPLE, 0);
		chk(rd, last);
		apb(1, `DBIP_OFF_MASK, 1);
		chk(irq, 1);
		apb(1, `DBIP_OFF_ALMSRC, 1);
		chk(pin, 0);
		apb(1, `DBIP_OFF_GENCFG, 1);
		chk(pin, 1);
		apb(1, `DBIP_OFF_STATUS, 1);
		chk({irq, pin}, 0);
		apb(1, `DBIP_OFF_MASK, 0);
		pair(1);
		chk(irq, 0);
		chk(pin, 1);
		apb(1, `DBIP_OFF_GENCFG, 2);
		for (k = 0; k < 8; k = k + 1) begin
			rd = $urandom;
			serial_rd_data <= rd[0];
			serial_drive_req <= rd[1];
			repeat (3) @(posedge pclk);
			chk({pin, soe, sdio}, {rd[0], rd[1], rd[0] & rd[1]});
		end
		transmit_gate <= 1'b0;
		serial_rd_data <= 1'b0;
		pair(0);
		apb(0, `DBIP_OFF_STATUS, 0);
		chk({sample_a, sample_b}, 0);
		chk(rd[`DBIP_ST_GATE], 1);
		chk(pin, 0);
		transmit_gate <= 1'b1;
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(pin, 1);
		apb(0, `DBIP_OFF_GENCFG, 0);
		chk(rd, 0);
		stop_test;
	end
endmodule // ddr_byte_input_port_alarm_pin_tb
